/* File: adc_pd_pkg.sv */
package adc_pd_pkg;

  // Power-mode bit codes
  localparam logic [1:0] PD_DEEP    = 2'h0;
  localparam logic [1:0] PD_FAST    = 2'h1;
  localparam logic [1:0] PD_INT_CLK = 2'h2;
  localparam logic [1:0] PD_EXT_CLK = 2'h3;

  // Control byte layout
  localparam int         CTRL_W         = 8;
  localparam int         CTRL_PD_LO_POS = 0;
  localparam int         CTRL_PD_HI_POS = 1;

  // Result and sample widths
  localparam int         RES_W    = 10;
  localparam int         SAMPLE_W = 11;
  localparam int         OUT_W    = 16;

  // Reset values
  localparam logic [1:0]       MODE_RST   = PD_INT_CLK;
  localparam logic [RES_W-1:0] RESULT_RST = 10'h000;
  localparam logic [7:0]       CTRL_RST   = 8'h00;

  // Conversion clock rates and divider counts
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned FAST_CLK_HZ = 1_800_000;
  localparam int unsigned SLOW_CLK_HZ = 225_000;
  localparam int unsigned EXT_CLK_HZ  = 2_000_000;
  localparam logic [8:0]  DIV_FAST    = 9'(CLK_HZ / FAST_CLK_HZ);
  localparam logic [8:0]  DIV_SLOW    = 9'(CLK_HZ / SLOW_CLK_HZ);
  localparam logic [8:0]  DIV_EXT     = 9'(CLK_HZ / EXT_CLK_HZ);

  // Power states
  typedef enum logic [2:0] {
    deep_sleep_state,
    fast_sleep_state,
    awake_state,
    convert_state,
    hw_down_state
  } pwr_state_t;

  // Mode bits out of a control byte
  function automatic logic [1:0] pd_bits(input logic [CTRL_W-1:0] b);
    return {b[CTRL_PD_HI_POS], b[CTRL_PD_LO_POS]};
  endfunction : pd_bits

endpackage : adc_pd_pkg

/* File: adc_link_if.sv */
`timescale 1ns/1ns
`default_nettype none
// Signals between the serial link domain and the core domain
interface adc_link_if;
  import adc_pd_pkg::*;
  logic              start_tgl;
  logic              byte_tgl;
  logic [CTRL_W-1:0] ctrl_byte;
  logic              done_tgl;
  logic [RES_W-1:0]  result;
  modport link (output start_tgl, output byte_tgl, output ctrl_byte,
                input done_tgl, input result);
  modport core (input start_tgl, input byte_tgl, input ctrl_byte,
                output done_tgl, output result);
endinterface : adc_link_if
`default_nettype wire

/* File: adc_serial_link.sv */
`timescale 1ns/1ns
`default_nettype none
module adc_serial_link
  import adc_pd_pkg::*;
(
  // Link clock and reset
  input  wire logic  sclk,
  input  wire logic  reset_n,
  // Serial pins
  input  wire logic  cs_n,
  input  wire logic  din,
  output logic       dout,
  output logic       dout_oe,
  // Core side
  adc_link_if.link   lk
);

  logic [3:0]        bit_cnt,   next_bit_cnt;
  logic [CTRL_W-1:0] shift_in,  next_shift_in;
  logic              start_tgl, next_start_tgl;
  logic              byte_tgl,  next_byte_tgl;
  logic [CTRL_W-1:0] ctrl,      next_ctrl;
  logic [OUT_W-1:0]  out_sh,    next_out_sh;
  logic              done_s1, done_s2, done_s3;

  // Start hunt, control byte capture and result shifting
  always_comb
  begin
    next_bit_cnt   = bit_cnt;
    next_shift_in  = shift_in;
    next_start_tgl = start_tgl;
    next_byte_tgl  = byte_tgl;
    next_ctrl      = ctrl;
    next_out_sh    = out_sh;
    if (cs_n)
    begin
      next_bit_cnt = 4'h0;
    end
    else
    begin
      next_out_sh = {out_sh[OUT_W-2:0], 1'b0};
      if (bit_cnt == 4'h0)
      begin
        if (din)
        begin
          next_start_tgl = ~start_tgl;
          next_shift_in  = {{(CTRL_W-1){1'b0}}, 1'b1};
          next_bit_cnt   = 4'h1;
        end
      end
      else
      begin
        next_shift_in = {shift_in[CTRL_W-2:0], din};
        if (bit_cnt == 4'h7)
        begin
          next_ctrl     = {shift_in[CTRL_W-2:0], din};
          next_byte_tgl = ~byte_tgl;
          next_bit_cnt  = 4'h0;
        end
        else
        begin
          next_bit_cnt = bit_cnt + 4'h1;
        end
      end
    end
    // New result loads whatever the core power state is
    if (done_s2 != done_s3)
    begin
      next_out_sh = {lk.result, {(OUT_W-RES_W){1'b0}}};
    end
  end

  // Link registers and done crossing
  always_ff @(posedge sclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bit_cnt   <= 4'h0;
      shift_in  <= CTRL_RST;
      start_tgl <= 1'b0;
      byte_tgl  <= 1'b0;
      ctrl      <= CTRL_RST;
      out_sh    <= {OUT_W{1'b0}};
      done_s1   <= 1'b0;
      done_s2   <= 1'b0;
      done_s3   <= 1'b0;
    end
    else
    begin
      bit_cnt   <= next_bit_cnt;
      shift_in  <= next_shift_in;
      start_tgl <= next_start_tgl;
      byte_tgl  <= next_byte_tgl;
      ctrl      <= next_ctrl;
      out_sh    <= next_out_sh;
      done_s1   <= lk.done_tgl;
      done_s2   <= done_s1;
      done_s3   <= done_s2;
    end
  end

  assign lk.start_tgl = start_tgl;
  assign lk.byte_tgl  = byte_tgl;
  assign lk.ctrl_byte = ctrl;
  assign dout         = out_sh[OUT_W-1];
  assign dout_oe      = ~cs_n;

  start_bit_a : assert property (@(posedge sclk) disable iff (!reset_n)
    !cs_n && din && bit_cnt == 4'h0 |=> start_tgl != $past(start_tgl) && bit_cnt == 4'h1)
    else $error("start bit not taken");

endmodule : adc_serial_link
`default_nettype wire

/* File: adc_sar_engine.sv */
`timescale 1ns/1ns
`default_nettype none
module adc_sar_engine
  import adc_pd_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                ce,
  // Control
  input  wire logic                start,
  input  wire logic                abort,
  input  wire logic                step,
  input  wire logic [SAMPLE_W-1:0] sample,
  // Result
  output logic                     busy,
  output logic                     done,
  output logic [RES_W-1:0]         code
);

  // Trial code kept when its lower transition lies at or below the sample
  function automatic logic keep_trial(input logic [RES_W-1:0] t,
                                      input logic [SAMPLE_W-1:0] s);
    return ({t, 1'b0} - 11'h001) <= s;
  endfunction : keep_trial

  logic [SAMPLE_W-1:0] held,  next_held;
  logic [RES_W-1:0]    trial, next_trial;
  logic [3:0]          idx,   next_idx;
  logic                next_busy, next_done;
  logic [RES_W-1:0]    next_code;
  logic [RES_W-1:0]    cand;

  // Successive approximation, MSB first
  always_comb
  begin
    next_held  = held;
    next_trial = trial;
    next_idx   = idx;
    next_busy  = busy;
    next_done  = 1'b0;
    next_code  = code;
    cand       = trial | (10'h001 << idx);
    if (abort)
    begin
      next_busy = 1'b0;
    end
    else if (start)
    begin
      next_held  = sample;
      next_trial = RESULT_RST;
      next_idx   = 4'(RES_W - 1);
      next_busy  = 1'b1;
    end
    else if (busy && step)
    begin
      if (keep_trial(cand, held))
      begin
        next_trial = cand;
      end
      if (idx == 4'h0)
      begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_code = keep_trial(cand, held) ? cand : trial;
      end
      else
      begin
        next_idx = idx - 4'h1;
      end
    end
  end

  // Engine registers
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      held  <= {SAMPLE_W{1'b0}};
      trial <= RESULT_RST;
      idx   <= 4'h0;
      busy  <= 1'b0;
      done  <= 1'b0;
      code  <= RESULT_RST;
    end
    else if (ce)
    begin
      held  <= next_held;
      trial <= next_trial;
      idx   <= next_idx;
      busy  <= next_busy;
      done  <= next_done;
      code  <= next_code;
    end
  end

  code_round_a : assert property (@(posedge clk) disable iff (!reset_n)
    done |-> (code == 10'h000 || ({code, 1'b0} - 11'h001) <= held)
          && (code == 10'h3FF || ({code, 1'b0} + 11'h001) > held))
    else $error("result not rounded to nearest code");

endmodule : adc_sar_engine
`default_nettype wire

/* File: adc_power_down_clock_mode_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
module adc_power_down_clock_mode_ctrl
  import adc_pd_pkg::*;
(
  // Core clock, reset and enable
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                ce,
  // Serial link
  input  wire logic                sclk,
  input  wire logic                cs_n,
  input  wire logic                din,
  output logic                     dout,
  output logic                     dout_oe,
  output logic                     sstrb,
  // Shutdown pin, as sensed level and float detect
  input  wire logic                hw_powerdown_n,
  input  wire logic                hw_powerdown_float,
  // Analog front end
  input  wire logic [SAMPLE_W-1:0] sample,
  // Power and status
  output logic                     analog_on,
  output logic                     bandgap_on,
  output logic                     comp_internal,
  output logic [1:0]               clock_mode,
  output logic                     conv_busy
);

  adc_link_if lk ();

  pwr_state_t       state, next_state;
  logic [1:0]       mode,  next_mode;
  // Clock mode kept across power-down codes
  logic             ext_sel, next_ext_sel;
  logic [8:0]       div_cnt, next_div_cnt;
  logic             done_tgl, next_done_tgl;
  logic [RES_W-1:0] result, next_result;
  logic [8:0]       div_lim;
  logic             tick, conv_start, conv_done;
  logic [RES_W-1:0] conv_code;

  // Pin and crossing synchronisers
  logic             pdn_s1, pdn_s2, flt_s1, flt_s2;
  logic             st_s1, st_s2, st_s3, by_s1, by_s2, by_s3;
  logic             start_edge, byte_edge, hw_req;

  adc_serial_link u_link (
    .sclk    (sclk),
    .reset_n (reset_n),
    .cs_n    (cs_n),
    .din     (din),
    .dout    (dout),
    .dout_oe (dout_oe),
    .lk      (lk.link)
  );

  adc_sar_engine u_sar (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (ce),
    .start   (conv_start),
    .abort   (hw_req),
    .step    (tick),
    .sample  (sample),
    .busy    (conv_busy),
    .done    (conv_done),
    .code    (conv_code)
  );

  // Two-stage syncs, third stage only for toggle edges
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pdn_s1  <= 1'b1;
      pdn_s2  <= 1'b1;
      flt_s1  <= 1'b0;
      flt_s2  <= 1'b0;
      st_s1   <= 1'b0;
      st_s2   <= 1'b0;
      st_s3   <= 1'b0;
      by_s1   <= 1'b0;
      by_s2   <= 1'b0;
      by_s3   <= 1'b0;
    end
    else if (ce)
    begin
      pdn_s1  <= hw_powerdown_n;
      pdn_s2  <= pdn_s1;
      flt_s1  <= hw_powerdown_float;
      flt_s2  <= flt_s1;
      st_s1   <= lk.start_tgl;
      st_s2   <= st_s1;
      st_s3   <= st_s2;
      by_s1   <= lk.byte_tgl;
      by_s2   <= by_s1;
      by_s3   <= by_s2;
    end
  end

  // Decoded pin: float wins over the sensed level
  assign hw_req     = ~flt_s2 & ~pdn_s2;
  assign start_edge = st_s2 != st_s3;
  assign byte_edge  = by_s2 != by_s3;

  // Conversion clock divider choice
  always_comb
  begin
    if (ext_sel)
    begin
      div_lim = DIV_EXT;
    end
    else if (flt_s2)
    begin
      div_lim = DIV_FAST;
    end
    else
    begin
      div_lim = DIV_SLOW;
    end
  end

  assign tick       = div_cnt >= div_lim - 9'h001;
  assign conv_start = byte_edge && !hw_req;

  // Power state machine
  always_comb
  begin
    next_state    = state;
    next_mode     = mode;
    next_ext_sel  = ext_sel;
    next_div_cnt  = tick ? 9'h000 : div_cnt + 9'h001;
    next_done_tgl = done_tgl;
    next_result   = result;
    if (state != convert_state)
    begin
      next_div_cnt = 9'h000;
    end
    case (state)
      hw_down_state:
      begin
        if (!hw_req)
        begin
          next_state = awake_state;
        end
      end
      deep_sleep_state, fast_sleep_state:
      begin
        if (start_edge)
        begin
          next_state = awake_state;
        end
      end
      awake_state:
      begin
      end
      convert_state:
      begin
        if (conv_done)
        begin
          next_result   = conv_code;
          next_done_tgl = ~done_tgl;
          case (mode)
            PD_DEEP: next_state = deep_sleep_state;
            PD_FAST: next_state = fast_sleep_state;
            default: next_state = awake_state;
          endcase
        end
      end
      default:
      begin
        next_state = awake_state;
      end
    endcase
    // A new control byte outside shutdown sets the mode and starts, even mid-conversion
    if (conv_start)
    begin
      next_mode    = pd_bits(lk.ctrl_byte);
      // Power-down codes keep the clock mode chosen last
      if (lk.ctrl_byte[CTRL_PD_HI_POS])
      begin
        next_ext_sel = lk.ctrl_byte[CTRL_PD_LO_POS];
      end
      next_state   = convert_state;
      next_div_cnt = 9'h000;
    end
    if (hw_req)
    begin
      next_state = hw_down_state;
    end
  end

  // Power state registers
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state    <= awake_state;
      mode     <= MODE_RST;
      ext_sel  <= MODE_RST == PD_EXT_CLK;
      div_cnt  <= 9'h000;
      done_tgl <= 1'b0;
      result   <= RESULT_RST;
    end
    else if (ce)
    begin
      state    <= next_state;
      mode     <= next_mode;
      ext_sel  <= next_ext_sel;
      div_cnt  <= next_div_cnt;
      done_tgl <= next_done_tgl;
      result   <= next_result;
    end
  end

  // Supplies per state
  assign analog_on     = state == awake_state || state == convert_state;
  assign bandgap_on    = analog_on || state == fast_sleep_state;
  assign comp_internal = ~flt_s2;
  assign clock_mode    = mode;
  assign sstrb         = state != convert_state;
  assign lk.done_tgl   = done_tgl;
  assign lk.result     = result;

  hw_abort_a : assert property (@(posedge clk) disable iff (!reset_n)
    ce && hw_req |=> state == hw_down_state && !conv_busy)
    else $error("shutdown pin did not abort");

  deep_after_a : assert property (@(posedge clk) disable iff (!reset_n)
    ce && state == convert_state && conv_done && mode == PD_DEEP && !hw_req && !byte_edge
    |=> state == deep_sleep_state)
    else $error("single conversion did not return to deep sleep");

  stay_up_a : assert property (@(posedge clk) disable iff (!reset_n)
    ce && state == convert_state && conv_done && mode[1] && !hw_req && !byte_edge
    |=> state == awake_state && analog_on)
    else $error("upper mode bit did not keep converter awake");

  wake_a : assert property (@(posedge clk) disable iff (!reset_n)
    ce && start_edge && !hw_req && !byte_edge
    && (state == deep_sleep_state || state == fast_sleep_state) |=> state == awake_state)
    else $error("start bit did not wake converter");

  sleep_power_a : assert property (@(posedge clk) disable iff (!reset_n)
    (state == deep_sleep_state |-> !bandgap_on && !analog_on && !conv_busy)
    and (state == fast_sleep_state |-> bandgap_on && !analog_on))
    else $error("sleep supplies wrong");

  finish_first_a : assert property (@(posedge clk) disable iff (!reset_n)
    ce && state == convert_state && !conv_done && !hw_req && !byte_edge
    |=> state == convert_state)
    else $error("conversion left before completion");

  div_sel_a : assert property (@(posedge clk) disable iff (!reset_n)
    !ext_sel |-> div_lim == (flt_s2 ? DIV_FAST : DIV_SLOW) && comp_internal == !flt_s2)
    else $error("conversion clock divider wrong for pin state");

  result_hand_a : assert property (@(posedge clk) disable iff (!reset_n)
    ce && state == convert_state && conv_done && !hw_req && !byte_edge
    |=> result == $past(conv_code) && done_tgl != $past(done_tgl))
    else $error("result not handed to link");

  byte_start_a : assert property (@(posedge clk) disable iff (!reset_n)
    ce && conv_start |=> state == convert_state && conv_busy
    && mode == $past({lk.ctrl_byte[CTRL_PD_HI_POS], lk.ctrl_byte[CTRL_PD_LO_POS]}))
    else $error("control byte did not start conversion");

  clk_keep_a : assert property (@(posedge clk) disable iff (!reset_n)
    ce && conv_start && !lk.ctrl_byte[CTRL_PD_HI_POS] |=> ext_sel == $past(ext_sel))
    else $error("power-down byte changed the clock mode");

  clk_pick_a : assert property (@(posedge clk) disable iff (!reset_n)
    ce && conv_start && lk.ctrl_byte[CTRL_PD_HI_POS] |=> ext_sel == $past(lk.ctrl_byte[0]))
    else $error("clock mode byte not applied");

  hw_refuse_a : assert property (@(posedge clk) disable iff (!reset_n)
    ce && hw_req && byte_edge |=> state == hw_down_state && mode == $past(mode))
    else $error("byte taken during shutdown");

  hw_leave_a : assert property (@(posedge clk) disable iff (!reset_n)
    ce && state == hw_down_state && !hw_req && !byte_edge |=> state == awake_state)
    else $error("shutdown release did not wake converter");

  slow_tick_a : assert property (@(posedge clk) disable iff (!reset_n)
    ce && tick && !ext_sel && !flt_s2 |-> div_cnt == DIV_SLOW - 9'h001)
    else $error("slow conversion clock period wrong");

  fast_tick_a : assert property (@(posedge clk) disable iff (!reset_n)
    ce && tick && !ext_sel && flt_s2 |-> div_cnt == DIV_FAST - 9'h001)
    else $error("fast conversion clock period wrong");

  deep_idle_a : assert property (@(posedge clk) disable iff (!reset_n)
    ce && state == deep_sleep_state && !start_edge && !byte_edge && !hw_req
    |=> state == deep_sleep_state && !conv_busy)
    else $error("deep sleep left without a start bit");

  result_keep_a : assert property (@(posedge clk) disable iff (!reset_n)
    state != convert_state |=> result == $past(result))
    else $error("stored result lost outside conversion");

endmodule : adc_power_down_clock_mode_ctrl
`default_nettype wire

/* File: host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module host_model
(
  // Serial pins driven by the host
  output var logic sclk,
  output var logic cs_n,
  output var logic din,
  // Result pins from the converter
  input  wire logic dout,
  input  wire logic dout_oe
);
  // Link clock idles low, frame deselected
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b1;
  end

  // One 15 ns link period, data set while the clock is low
  task automatic pulse(input logic d);
    din = d;
    #7 sclk = 1'b1;
    #8 sclk = 1'b0;
  endtask : pulse

  // Control byte, MSB first, so the set top bit is the start bit
  task automatic send_byte(input logic [7:0] b);
    cs_n = 1'b0;
    #8;
    for (int i = 7; i >= 0; i--)
      pulse(b[i]);
    #8 cs_n = 1'b1;
    din = ~din;  // Deselected line shows no stale value
  endtask : send_byte

  // Clock out the result with din low, so no start bit is sent
  task automatic read_result(output logic [25:0] bits);
    cs_n = 1'b0;
    #8;
    for (int i = 25; i >= 0; i--)
    begin
      pulse(1'b0);
      bits[i] = (dout_oe === 1'b1) ? dout : 1'bx;
    end
    #8 cs_n = 1'b1;
    din = 1'b1;
  endtask : read_result
endmodule : host_model
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import adc_pd_pkg::*;
  // Core side drives
  logic                clk, reset_n, ce;
  logic                hw_powerdown_n, hw_powerdown_float;
  logic [SAMPLE_W-1:0] sample;
  // Link pins and status
  logic                sclk, cs_n, din, dout, dout_oe, sstrb;
  logic                analog_on, bandgap_on, comp_internal, conv_busy;
  logic [1:0]          clock_mode;
  int                  error_cnt, n_compared;
  logic                ext_last;  // Clock mode a power-down byte keeps

  // Block under test
  adc_power_down_clock_mode_ctrl i_adc_power_down_clock_mode_ctrl (
    .clk(clk), .reset_n(reset_n), .ce(ce), .sclk(sclk), .cs_n(cs_n),
    .din(din), .dout(dout), .dout_oe(dout_oe), .sstrb(sstrb),
    .hw_powerdown_n(hw_powerdown_n), .hw_powerdown_float(hw_powerdown_float),
    .sample(sample), .analog_on(analog_on), .bandgap_on(bandgap_on),
    .comp_internal(comp_internal), .clock_mode(clock_mode), .conv_busy(conv_busy));
  // Host serial master
  host_model i_host_model (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
    .dout_oe(dout_oe));

  // Core clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Advance to just after a rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // Compare and report
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  // Half-LSB sample to straight binary code, saturating
  function automatic logic [RES_W-1:0] exp_code(input logic [SAMPLE_W-1:0] s);
    logic [SAMPLE_W:0] k;
    k = ({1'b0, s} + 12'h001) >> 1;
    return (k > 12'h3FF) ? 10'h3FF : k[RES_W-1:0];
  endfunction : exp_code

  // Wait for a strobe level, counting cycles
  task automatic wait_strobe(input logic lvl, input int lim, output int n);
    n = 0;
    while (sstrb !== lvl && n < lim)
    begin
      cyc(1);
      n++;
      if (lvl && sstrb === 1'b0)
        check("awake_in_conv", 1, analog_on);
    end
  endtask : wait_strobe

  // One full conversion in mode m, then readback
  task automatic run_conv(input logic [1:0] m);
    int n, lim;
    logic [25:0] rx;
    cyc(200);
    sample = SAMPLE_W'($urandom);
    i_host_model.send_byte({1'b1, 5'($urandom), m});
    wait_strobe(1'b0, 20, n);
    check("strobe_low", 0, sstrb);
    check("woken", 1, analog_on);
    check("clock_mode", m, clock_mode);
    wait_strobe(1'b1, 5000, n);
    check("strobe_high", 1, sstrb);
    if (m[1])
      ext_last = m[0];
    lim = ext_last ? int'(DIV_EXT) : hw_powerdown_float ? int'(DIV_FAST) : int'(DIV_SLOW);
    lim = 10 * lim;
    check("conv_len", 1, (n + 60 >= lim) && (n <= lim + 4));
    cyc(3);
    check("analog_on", m[1], analog_on);
    check("bandgap_on", m != PD_DEEP, bandgap_on);
    check("comp_internal", !hw_powerdown_float, comp_internal);
    i_host_model.read_result(rx);
    check("result", {exp_code(sample), 6'h00}, rx[23:8]);
    check("result_pad", 16'h0000, {6'h00, rx[25:24], rx[7:0]});
  endtask : run_conv

  // Verdict and end of run
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  // Main sequence
  initial
  begin
    int n;
    error_cnt = 0;
    n_compared = 0;
    reset_n = 1'b0;
    ce = 1'b1;
    hw_powerdown_n = 1'b1;
    hw_powerdown_float = 1'b0;
    sample = '0;
    void'($urandom(32'h6EEE7F49));
    cyc(16);
    check("rst_strobe", 1, sstrb);
    check("rst_analog", 1, analog_on);
    check("rst_bandgap", 1, bandgap_on);
    check("rst_busy", 0, conv_busy);
    check("rst_mode", PD_INT_CLK, clock_mode);
    reset_n = 1'b1;
    $display("test reset done");
    // Power-up: dummy conversion, then settle in fast sleep
    ext_last = 1'b0;
    hw_powerdown_float = 1'b1;
    run_conv(PD_FAST);
    cyc(7500);
    $display("test power-up done");
    // Every mode with the pin high, then floating
    for (int i = 0; i < 8; i++)
    begin
      hw_powerdown_float = i[2];
      run_conv(i[1:0]);
    end
    for (int j = 0; j < 4; j++)
      run_conv(2'($urandom));
    $display("test modes done");
    // Shutdown mid-conversion, then a refused byte
    hw_powerdown_float = 1'b0;
    cyc(200);
    i_host_model.send_byte({1'b1, 5'h00, PD_INT_CLK});
    wait_strobe(1'b0, 20, n);
    cyc(100);
    check("busy_mid", 1, conv_busy);
    // Frozen core must not see the pin until enabled again
    ce = 1'b0;
    hw_powerdown_n = 1'b0;
    cyc(10);
    check("ce_hold_busy", 1, conv_busy);
    check("ce_hold_strobe", 0, sstrb);
    ce = 1'b1;
    cyc(4);
    check("hw_analog", 0, analog_on);
    check("hw_bandgap", 0, bandgap_on);
    check("hw_strobe", 1, sstrb);
    check("hw_busy", 0, conv_busy);
    i_host_model.send_byte({1'b1, 5'h00, PD_EXT_CLK});
    cyc(20);
    check("hw_refuse", 1, sstrb);
    check("hw_mode", PD_INT_CLK, clock_mode);
    hw_powerdown_n = 1'b1;
    cyc(200);
    check("hw_release", 1, analog_on);
    run_conv(PD_INT_CLK);
    $display("test shutdown done");
    end_sim();
  end

  // Watchdog
  initial
  begin
    #700000;
    error_cnt++;
    $display("mismatch watchdog expected finish seen timeout");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
